// >>> shared/ptsp_regs.vh
`ifndef PTSP_REGS_VH
`define PTSP_REGS_VH
// Function
// - prescale select: 1, 4, 8, 16
// - count up to period, then wrap to zero
// - count equal period sets match flag
// - reset: count zero, period all ones
// - count and period fully read/write
// - on bit 2 runs or stops timer
// - prescaler cleared on count/control write, reset
// - control write keeps timer count
// - control bits 7 to 3 read zero
// - applied duty never exceeds programmed duty; in slave mode sync does not clear count, so high time can exceed it
// - programmed duty stays static, no adjustment
// - stand-alone: pwm is system clock
// - master drives system clock on sync pin
// - slave ORs sync with match, loads buffers
// - slave start delayed by phase value
// - period register sets pwm period
// - wrap cycle clears count, loads duty
// - duty buffer takes effect after match
// - sleep freezes timer and module state, all but bus ack and read data

// ----------------------------------------
// register word offsets (byte address bits 5:2)
// ----------------------------------------
`define PTSP_ADR_CONTROL  4'h0
`define PTSP_ADR_PERIOD   4'h1
`define PTSP_ADR_COUNT    4'h2
`define PTSP_ADR_DUTY     4'h3
`define PTSP_ADR_PHASE    4'h4
`define PTSP_ADR_MODE     4'h5
`define PTSP_ADR_FLAGS    4'h6
`define PTSP_ADR_ACTIVE   4'h7

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PTSP_CTL_ON       2
`define PTSP_CTL_MASK     3'h7
`define PTSP_PERIOD_RST   8'hFF
`define PTSP_COUNT_RST    8'h00
`define PTSP_MODE_STAND   2'h0
`define PTSP_MODE_MASTER  2'h1
`define PTSP_MODE_SLAVE   2'h2
`define PTSP_PS_DIV1      4'h0
`define PTSP_PS_DIV4      4'h3
`define PTSP_PS_DIV8      4'h7
`define PTSP_PS_DIV16     4'hF
`endif

// >>> logic/ptsp_timer_pwm.v
`timescale 1ns/10ps
`include "ptsp_regs.vh"
module ptsp_timer_pwm (
    input  wire        clk,
    input  wire        rst,
    input  wire        clk_en,
    input  wire        sleep,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [31:0] wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    input  wire        sync_clock_input,
    output reg         sync_pin_out,
    output reg         sync_pin_oe,
    output reg         system_clock,
    output reg         match_flag
);

// ----------------------------------------
// state
// ----------------------------------------
reg  [2:0] timer_control;
reg  [7:0] period_value;
reg  [7:0] timer_count;
reg  [7:0] duty_buffer;
reg  [7:0] duty_active;
reg  [7:0] phase_buffer;
reg  [7:0] phase_active;
reg  [1:0] sync_mode;
reg  [3:0] prescale_cnt;
reg        sync_meta;
reg        sync_q;
reg        sync_prev;
reg        phase_wait;
reg  [7:0] phase_cnt;
reg  [3:0] ps_limit;
reg  [31:0] next_rdata;

wire       run      = clk_en & ~sleep;
wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire [3:0] word     = wb_adr_i[5:2];
wire       hit      = (wb_adr_i[31:6] == 26'h0) & (word <= `PTSP_ADR_ACTIVE);
wire       wr       = req & wb_we_i & wb_sel_i[0] & hit;
wire       wr_ctl   = wr & (word == `PTSP_ADR_CONTROL);
wire       wr_cnt   = wr & (word == `PTSP_ADR_COUNT);
wire       wr_flag  = wr & (word == `PTSP_ADR_FLAGS);
wire       timer_on = timer_control[`PTSP_CTL_ON];
wire       tick     = timer_on & (prescale_cnt == ps_limit);
wire       match    = (timer_count == period_value);
wire       wrap     = tick & match;
wire       slave    = (sync_mode == `PTSP_MODE_SLAVE);
wire       sync_rise = sync_q & ~sync_prev;
// slave reloads on master edge or own match
wire       load     = slave ? (sync_rise | wrap) : wrap;

assign wb_err_o = 1'b0;

always @*
begin
    case (timer_control[1:0])
        2'h0:    ps_limit = `PTSP_PS_DIV1;
        2'h1:    ps_limit = `PTSP_PS_DIV4;
        2'h2:    ps_limit = `PTSP_PS_DIV8;
        default: ps_limit = `PTSP_PS_DIV16;
    endcase
end

// ----------------------------------------
// read mux
// ----------------------------------------
always @*
begin
    next_rdata = 32'h0;
    case (word)
        `PTSP_ADR_CONTROL: next_rdata[7:0] = {5'h0, timer_control};
        `PTSP_ADR_PERIOD:  next_rdata[7:0] = period_value;
        `PTSP_ADR_COUNT:   next_rdata[7:0] = timer_count;
        `PTSP_ADR_DUTY:    next_rdata[7:0] = duty_buffer;
        `PTSP_ADR_PHASE:   next_rdata[7:0] = phase_buffer;
        `PTSP_ADR_MODE:    next_rdata[7:0] = {6'h0, sync_mode};
        `PTSP_ADR_FLAGS:   next_rdata[7:0] = {7'h0, match_flag};
        `PTSP_ADR_ACTIVE:  next_rdata[15:0] = {phase_active, duty_active};
        default:           next_rdata = 32'h0;
    endcase
    if (!hit)
        next_rdata = 32'h0;
end

// ----------------------------------------
// bus slave
// ----------------------------------------
// ack is not gated by clk_en or sleep so the bus never hangs
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
    end
    else
    begin
        wb_ack_o <= req;
        if (req)
            wb_dat_o <= next_rdata;
    end
end

// ----------------------------------------
// sync input synchroniser
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        // idle level of the pulled-up pin, so no false edge after reset
        sync_meta <= 1'b1;
        sync_q    <= 1'b1;
        sync_prev <= 1'b1;
    end
    else if (run)
    begin
        sync_meta <= sync_clock_input;
        sync_q    <= sync_meta;
        sync_prev <= sync_q;
    end
end

// ----------------------------------------
// software registers
// ----------------------------------------
// register writes are frozen with the rest while clk_en is low or sleep holds
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        timer_control <= 3'h0;
        period_value  <= `PTSP_PERIOD_RST;
        duty_buffer   <= 8'h0;
        phase_buffer  <= 8'h0;
        sync_mode     <= `PTSP_MODE_STAND;
    end
    else if (run)
    begin
        if (wr_ctl)
            timer_control <= wb_dat_i[2:0] & `PTSP_CTL_MASK;
        if (wr & (word == `PTSP_ADR_PERIOD))
            period_value <= wb_dat_i[7:0];
        if (wr & (word == `PTSP_ADR_DUTY))
            duty_buffer <= wb_dat_i[7:0];
        if (wr & (word == `PTSP_ADR_PHASE))
            phase_buffer <= wb_dat_i[7:0];
        if (wr & (word == `PTSP_ADR_MODE))
            sync_mode <= wb_dat_i[1:0];
    end
end

// ----------------------------------------
// prescaler
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        prescale_cnt <= 4'h0;
    end
    else if (run)
    begin
        if (wr_ctl | wr_cnt)
            prescale_cnt <= 4'h0;
        else if (timer_on)
            prescale_cnt <= tick ? 4'h0 : prescale_cnt + 4'h1;
    end
end

// ----------------------------------------
// timer count
// ----------------------------------------
wire [7:0] next_count = timer_count + 8'h01;

always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        timer_count <= `PTSP_COUNT_RST;
    end
    else if (run)
    begin
        if (wr_cnt)
            timer_count <= wb_dat_i[7:0];
        else if (wrap)
            timer_count <= 8'h00;
        else if (tick)
            timer_count <= next_count;
    end
end

// ----------------------------------------
// match flag
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        match_flag <= 1'b0;
    end
    else if (run)
    begin
        // set wins over a software clear in the same cycle
        if (timer_on & match)
            match_flag <= 1'b1;
        else if (wr_flag & wb_dat_i[0])
            match_flag <= 1'b0;
    end
end

// ----------------------------------------
// active duty and phase
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        duty_active  <= 8'h0;
        phase_active <= 8'h0;
    end
    else if (run)
    begin
        if (load)
        begin
            duty_active  <= duty_buffer;
            phase_active <= phase_buffer;
        end
    end
end

// ----------------------------------------
// system clock and slave phase delay
// ----------------------------------------
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        system_clock <= 1'b0;
        phase_wait   <= 1'b0;
        phase_cnt    <= 8'h0;
    end
    else if (run)
    begin
        // duty only reloads from software buffer, never tuned here
        if (slave & load)
        begin
            system_clock <= 1'b0;
            phase_wait   <= 1'b1;
            phase_cnt    <= 8'h0;
        end
        else if (slave & phase_wait)
        begin
            if (tick)
            begin
                if (phase_cnt == phase_active)
                begin
                    phase_wait   <= 1'b0;
                    system_clock <= (duty_active != 8'h0);
                end
                else
                    phase_cnt <= phase_cnt + 8'h01;
            end
        end
        else if (wrap & !slave)
            system_clock <= (duty_buffer != 8'h0);
        // drop on the tick that brings the count to duty: high for duty ticks outside slave mode
        else if (tick & (next_count == duty_active))
            system_clock <= 1'b0;
    end
end

// ----------------------------------------
// sync pin drive
// ----------------------------------------
// pin trails system_clock by one cycle, the price of a registered pad
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        sync_pin_out <= 1'b0;
        sync_pin_oe  <= 1'b0;
    end
    else if (run)
    begin
        sync_pin_oe  <= (sync_mode == `PTSP_MODE_MASTER);
        sync_pin_out <= (sync_mode == `PTSP_MODE_MASTER) & system_clock;
    end
end

endmodule // ptsp_timer_pwm

// >>> tb/ptsp_monitor.sv
`timescale 1ns/10ps
module ptsp_monitor (
    input wire        clk,
    input wire        rst,
    input wire        sleep,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire        sync_pin_out,
    input wire        sync_pin_oe,
    input wire        system_clock,
    input wire        match_flag
);
    // ------
    // checks
    // ------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rd_s;
        wb_ack_o && !wb_we_i;
    endsequence
    bus_ack_a: assert property (req_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not single");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    err_low_a: assert property (!wb_err_o)
        else $error("err raised");
    ctl_read_a: assert property (rd_s ##0 (wb_adr_i == 32'h0) |-> wb_dat_o[31:3] == 29'h0)
        else $error("control upper bits set");
    unmap_read_a: assert property (rd_s ##0 (wb_adr_i > 32'h1F) |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    flag_hold_a: assert property (match_flag && !(wb_cyc_i && wb_we_i) |=> match_flag)
        else $error("flag dropped");
    sleep_hold_a: assert property (sleep |=> $stable(system_clock) && $stable(sync_pin_out))
        else $error("state moved in sleep");
    master_pin_a: assert property (sync_pin_oe && !sleep |-> sync_pin_out == $past(system_clock))
        else $error("sync pin differs");
endmodule // ptsp_monitor

bind ptsp_timer_pwm ptsp_monitor chk (.clk(clk), .rst(rst), .sleep(sleep), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sync_pin_out(sync_pin_out),
    .sync_pin_oe(sync_pin_oe), .system_clock(system_clock), .match_flag(match_flag));

// >>> tb/ptsp_sync_master.sv
`timescale 1ns/10ps
module ptsp_sync_master #(
    parameter PER = 20
) (
    input  wire clk,
    input  wire en,
    output reg  sync
);
    reg [7:0] cnt = 8'h00;
    initial sync = 1'b1;
    // released pin floats to its pull-up
    always @(posedge clk)
    begin
        cnt  <= (!en || cnt == PER - 1) ? 8'h00 : cnt + 8'h01;
        sync <= !en || cnt < 2;
    end
endmodule // ptsp_sync_master

// >>> tb/test_ptsp_timer_pwm.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("unexpected %0t mismatch", $time); end end
module test_ptsp_timer_pwm;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sleep = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] dat = 32'h0;
    logic        men = 1'b0;
    logic [31:0] q;
    logic [31:0] r;
    wire  [31:0] dat_o;
    wire         ack, sync_in, pin, oe, sc, mf;
    int          error_cnt = 0;
    int          n_compared = 0;
    realtime     t0, t1, t2;
    always #2 clk = ~clk;
    ptsp_timer_pwm uut (.clk(clk), .rst(rst), .clk_en(1'b1), .sleep(sleep), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .wb_err_o(), .sync_clock_input(sync_in), .sync_pin_out(pin), .sync_pin_oe(oe), .system_clock(sc),
        .match_flag(mf));
    ptsp_sync_master #(.PER(20)) far (.clk(clk), .en(men), .sync(sync_in));
    // ------
    // tasks
    // ------
    task bus(input [7:0] a, input w, input [7:0] d);
    begin
        cyc <= 1'b1;
        we  <= w;
        adr <= {24'h0, a};
        dat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = dat_o;
        cyc <= 1'b0;
        @(posedge clk);
    end
    endtask
    task test_done;
    begin
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    end
    endtask
    task t_regs;
    begin
        bus(8'h04, 0, 0);
        `CHK(q, 32'hFF)
        bus(8'h00, 1, 8'hFB);
        bus(8'h00, 0, 0);
        `CHK(q, 32'h03)
        bus(8'h04, 1, 8'hA5);
        bus(8'h04, 0, 0);
        `CHK(q, 32'hA5)
        bus(8'h08, 1, 8'h5A);
        bus(8'h00, 1, 8'h00);
        bus(8'h08, 0, 0);
        `CHK(q, 32'h5A)
        bus(8'h40, 1, 8'h77);
        bus(8'h40, 0, 0);
        `CHK(q, 32'h0)
        bus(8'h18, 1, 8'h01);
        `CHK(mf, 1'b0)
    end
    endtask
    task t_scale;
        int d;
    begin
        bus(8'h04, 1, 8'hFF);
        for (int c = 0; c < 4; c++)
        begin
            d = (c == 0) ? 1 : 4 << (c - 1);
            bus(8'h08, 1, 0);
            bus(8'h00, 1, {6'h01, c[1:0]});
            repeat (64 * d) @(posedge clk);
            bus(8'h00, 1, 0);
            bus(8'h08, 0, 0);
            `CHK(q >= 64 && q <= 67, 1'b1)
        end
    end
    endtask
    task t_pwm(input [7:0] m);
    begin
        bus(8'h14, 1, m);
        bus(8'h04, 1, 8'h04);
        bus(8'h0C, 1, 8'h02);
        bus(8'h00, 1, 8'h05);
        @(posedge sc);
        @(posedge sc);
        t0 = $realtime;
        @(negedge sc);
        t1 = $realtime;
        @(posedge sc);
        t2 = $realtime;
        `CHK(int'(t1 - t0), 32)
        `CHK(int'(t2 - t0), 80)
        `CHK(oe, m[0])
        `CHK(mf, 1'b1)
    end
    endtask
    task t_sleep;
    begin
        sleep <= 1'b1;
        bus(8'h08, 0, 0);
        r = q;
        repeat (40) @(posedge clk);
        bus(8'h08, 0, 0);
        `CHK(q, r)
        sleep <= 1'b0;
    end
    endtask
    task t_slave;
    begin
        bus(8'h14, 1, 8'h02);
        bus(8'h04, 1, 8'hFF);
        bus(8'h10, 1, 8'h03);
        bus(8'h00, 1, 8'h04);
        bus(8'h08, 1, 8'h00);
        men <= 1'b1;
        repeat (50) @(posedge clk);
        @(posedge sync_in);
        t0 = $realtime;
        @(posedge sc);
        `CHK(int'($realtime - t0) / 4 inside {[3:8]}, 1'b1)
        `CHK(oe, 1'b0)
    end
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_scale;
        t_pwm(8'h00);
        t_sleep;
        t_pwm(8'h01);
        t_slave;
        test_done;
    end
    // scenarios need under 5000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done;
    end
endmodule // test_ptsp_timer_pwm
